/* File: verilog/byte_op_decode_pkg.sv */
package byte_op_decode_pkg;

  typedef enum logic [3:0] {
    PHASE_DECODE  = 4'h1,
    PHASE_READ    = 4'h2,
    PHASE_PROCESS = 4'h4,
    PHASE_WRITE   = 4'h8
  } q_phase_t;

  localparam logic [7:0]  JUMP_FIRST_OPCODE   = 8'hEF;
  localparam logic [3:0]  JUMP_SECOND_OPCODE  = 4'hF;
  localparam logic [5:0]  INCREMENT_OPCODE    = 6'h0A;
  localparam logic [5:0]  COMPLEMENT_OPCODE   = 6'h07;
  localparam logic [6:0]  COMPARE_EQ_OPCODE   = 7'h31;
  localparam logic [7:0]  OFFSET_LIMIT        = 8'h5F;
  localparam logic [3:0]  ACCESS_HIGH_BANK    = 4'hF;
  localparam logic [7:0]  ACCESS_SPLIT        = 8'h60;
  localparam logic [15:0] EXT_CALL_VIA_W      = 16'h0014;
  localparam logic [5:0]  EXT_GROUP_OPCODE    = 6'h3A;
  localparam logic [1:0]  NOP_ONE             = 2'h1;
  localparam logic [1:0]  NOP_TWO             = 2'h2;
  localparam logic [7:0]  DATA_RESET          = 8'h00;
  localparam logic [11:0] ADDR_RESET          = 12'h000;
  localparam logic [20:0] PC_RESET            = 21'h000000;
  localparam logic [15:0] INSTR_RESET         = 16'h0000;

endpackage : byte_op_decode_pkg

/* File: verilog/operand_address_resolve.sv */
`timescale 1ns/10ps
module operand_address_resolve
  import byte_op_decode_pkg::*;
(
  input  wire logic [7:0]  file_field,
  input  wire logic        access_sel,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] frame_pointer,
  input  wire logic        ext_set_enable,
  output logic      [11:0] resolved_addr
);

  always_comb begin
    if (access_sel) begin
      resolved_addr = {bank_select_register, file_field};
    end else if (ext_set_enable && (file_field <= OFFSET_LIMIT)) begin
      // A zero frame pointer lands on the same low access locations as the literal map.
      resolved_addr = frame_pointer + {4'h0, file_field};
    end else if (file_field < ACCESS_SPLIT) begin
      resolved_addr = {4'h0, file_field};
    end else begin
      resolved_addr = {ACCESS_HIGH_BANK, file_field};
    end
  end

endmodule : operand_address_resolve

/* File: verilog/byte_op_decode_indexed_offset.sv */
`timescale 1ns/10ps
module byte_op_decode_indexed_offset
  import byte_op_decode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        ext_set_enable,
  input  wire logic [15:0] fetch_word,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] frame_pointer,
  input  wire logic [7:0]  file_rd_data,
  output q_phase_t         phase,
  output logic             file_rd_en,
  output logic [11:0]      file_addr,
  output logic             file_wr_en,
  output logic [7:0]       file_wr_data,
  output logic [7:0]       w_reg,
  output logic             carry_flag,
  output logic             digit_carry_flag,
  output logic             negative_flag,
  output logic             overflow_flag,
  output logic             zero_flag,
  output logic             pc_load,
  output logic [20:0]      pc_target,
  output logic             discard_fetch,
  output logic             ext_op_decoded,
  output logic             nop_cycle
);

  function automatic logic uses_access_bit(input logic [15:0] op);
    uses_access_bit = ((op[15:12] >= 4'h1) && (op[15:12] <= 4'hB)) ||
                      (op[15:10] == 6'h01) || (op[15:9] == 7'h01);
  endfunction : uses_access_bit

  function automatic logic is_two_word(input logic [15:0] op);
    is_two_word = (op[15:12] == 4'hC) || (op[15:9] == 7'h76) || (op[15:10] == 6'h3B);
  endfunction : is_two_word

  function automatic logic is_ext_op(input logic [15:0] op);
    is_ext_op = (op[15:10] == EXT_GROUP_OPCODE) || (op == EXT_CALL_VIA_W);
  endfunction : is_ext_op

  q_phase_t    next_phase;
  logic [15:0] instr;
  logic [15:0] next_instr;
  logic [1:0]  nop_count;
  logic [1:0]  next_nop_count;
  logic [7:0]  jump_low;
  logic [7:0]  next_jump_low;
  logic [7:0]  operand;
  logic [7:0]  next_operand;
  logic        skip_taken;
  logic        next_skip_taken;
  logic [11:0] next_file_addr;
  logic        next_file_wr_en;
  logic [7:0]  next_file_wr_data;
  logic [7:0]  next_w_reg;
  logic        next_carry;
  logic        next_digit_carry;
  logic        next_negative;
  logic        next_overflow;
  logic        next_zero;
  logic        next_pc_load;
  logic [20:0] next_pc_target;
  logic        next_ext_op;
  logic [11:0] resolved_addr;
  logic [7:0]  sum;
  logic        executing;
  logic        is_jump;
  logic        jump_pairs;
  logic        op_inc;
  logic        op_comp;
  logic        op_cmp;

  operand_address_resolve u_resolve (
    .file_field           (instr[7:0]),
    .access_sel           (instr[8]),
    .bank_select_register (bank_select_register),
    .frame_pointer        (frame_pointer),
    .ext_set_enable       (ext_set_enable),
    .resolved_addr        (resolved_addr)
  );

  assign executing = (nop_count == 2'h0);
  assign nop_cycle = ~executing;
  assign is_jump   = (instr[15:8] == JUMP_FIRST_OPCODE);
  // A jump whose second word is malformed loads nothing, so the fetched word must not be flagged as discarded.
  assign jump_pairs = is_jump && (fetch_word[15:12] == JUMP_SECOND_OPCODE);
  assign op_inc    = (instr[15:10] == INCREMENT_OPCODE);
  assign op_comp   = (instr[15:10] == COMPLEMENT_OPCODE);
  assign op_cmp    = (instr[15:9] == COMPARE_EQ_OPCODE);
  assign sum       = operand + 8'h01;

  // Read strobe only in the read phase so the file sees a single access per cycle.
  assign file_rd_en    = clk_en && executing && (phase == PHASE_READ) && uses_access_bit(instr);
  assign discard_fetch = clk_en && executing && (phase == PHASE_WRITE) && (skip_taken || jump_pairs);

  always_comb begin
    next_phase        = phase;
    next_instr        = instr;
    next_nop_count    = nop_count;
    next_jump_low     = jump_low;
    next_operand      = operand;
    next_skip_taken   = skip_taken;
    next_file_addr    = file_addr;
    next_file_wr_en   = 1'b0;
    next_file_wr_data = file_wr_data;
    next_w_reg        = w_reg;
    next_carry        = carry_flag;
    next_digit_carry  = digit_carry_flag;
    next_negative     = negative_flag;
    next_overflow     = overflow_flag;
    next_zero         = zero_flag;
    next_pc_load      = 1'b0;
    next_pc_target    = pc_target;
    next_ext_op       = 1'b0;
    case (phase)
      PHASE_DECODE: begin
        next_phase      = PHASE_READ;
        next_skip_taken = 1'b0;
        if (executing) begin
          next_jump_low = instr[7:0];
          next_ext_op   = ext_set_enable && is_ext_op(instr);
          if (uses_access_bit(instr)) begin
            next_file_addr = resolved_addr;
          end
        end
      end
      PHASE_READ: begin
        next_phase = PHASE_PROCESS;
        if (executing) begin
          next_operand = file_rd_data;
        end
      end
      PHASE_PROCESS: begin
        next_phase = PHASE_WRITE;
        if (executing && op_inc) begin
          next_carry       = (operand == 8'hFF);
          next_digit_carry = (operand[3:0] == 4'hF);
          next_negative    = sum[7];
          next_overflow    = (operand == 8'h7F);
          next_zero        = (sum == 8'h00);
          if (instr[9]) begin
            next_file_wr_en   = 1'b1;
            next_file_wr_data = sum;
          end else begin
            next_w_reg = sum;
          end
        end else if (executing && op_comp) begin
          next_negative = ~operand[7];
          next_zero     = (operand == 8'hFF);
          if (instr[9]) begin
            next_file_wr_en   = 1'b1;
            next_file_wr_data = ~operand;
          end else begin
            next_w_reg = ~operand;
          end
        end else if (executing && op_cmp) begin
          next_skip_taken = (operand == w_reg);
        end
      end
      PHASE_WRITE: begin
        next_phase = PHASE_DECODE;
        next_instr = fetch_word;
        if (!executing) begin
          next_nop_count = nop_count - 2'h1;
        end else if (jump_pairs) begin
          // The second word is consumed here, so the following cycle idles while the target is fetched.
          next_pc_load   = 1'b1;
          next_pc_target = {fetch_word[11:0], jump_low, 1'b0};
          next_nop_count = NOP_ONE;
        end else if (skip_taken) begin
          next_nop_count = is_two_word(fetch_word) ? NOP_TWO : NOP_ONE;
        end
      end
      default: begin
        next_phase = PHASE_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase            <= PHASE_DECODE;
      instr            <= INSTR_RESET;
      nop_count        <= 2'h0;
      jump_low         <= DATA_RESET;
      operand          <= DATA_RESET;
      skip_taken       <= 1'b0;
      file_addr        <= ADDR_RESET;
      file_wr_en       <= 1'b0;
      file_wr_data     <= DATA_RESET;
      w_reg            <= DATA_RESET;
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      negative_flag    <= 1'b0;
      overflow_flag    <= 1'b0;
      zero_flag        <= 1'b0;
      pc_load          <= 1'b0;
      pc_target        <= PC_RESET;
      ext_op_decoded   <= 1'b0;
    end else if (clk_en) begin
      phase            <= next_phase;
      instr            <= next_instr;
      nop_count        <= next_nop_count;
      jump_low         <= next_jump_low;
      operand          <= next_operand;
      skip_taken       <= next_skip_taken;
      file_addr        <= next_file_addr;
      file_wr_en       <= next_file_wr_en;
      file_wr_data     <= next_file_wr_data;
      w_reg            <= next_w_reg;
      carry_flag       <= next_carry;
      digit_carry_flag <= next_digit_carry;
      negative_flag    <= next_negative;
      overflow_flag    <= next_overflow;
      zero_flag        <= next_zero;
      pc_load          <= next_pc_load;
      pc_target        <= next_pc_target;
      ext_op_decoded   <= next_ext_op;
    end
  end

endmodule : byte_op_decode_indexed_offset

/* File: verification/byte_op_decode_props.sv */
`timescale 1ns/10ps
module byte_op_decode_props
  import byte_op_decode_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        ext_set_enable,
  input wire logic [15:0] fetch_word,
  input wire logic [3:0]  bank_select_register,
  input wire logic [11:0] frame_pointer,
  input wire logic [7:0]  file_rd_data,
  input wire q_phase_t    phase,
  input wire logic        file_rd_en,
  input wire logic [11:0] file_addr,
  input wire logic        file_wr_en,
  input wire logic [7:0]  file_wr_data,
  input wire logic        pc_load,
  input wire logic        discard_fetch,
  input wire logic        nop_cycle
);
  logic [15:0] ins;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow of the executing word, so the address checks can see a, f and the opcode.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ins <= INSTR_RESET;
    else if (clk_en && phase == PHASE_WRITE) ins <= fetch_word;
  end
  property p_wrap; clk_en && phase == PHASE_WRITE |=> phase == PHASE_DECODE; endproperty
  a_wrap: assert property (p_wrap) else $error("phase did not wrap");
  property p_read; file_rd_en |-> phase == PHASE_READ; endproperty
  a_read: assert property (p_read) else $error("read outside read phase");
  property p_inc; file_wr_en && ins[15:10] == INCREMENT_OPCODE
    |-> file_wr_data == $past(file_rd_data, 2) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("bad increment data");
  property p_off; file_rd_en && ext_set_enable && !ins[8] && ins[7:0] <= OFFSET_LIMIT
    |-> file_addr == frame_pointer + {4'h0, ins[7:0]}; endproperty
  a_off: assert property (p_off) else $error("bad offset address");
  property p_lit; file_rd_en && !ins[8] && !(ext_set_enable && ins[7:0] <= OFFSET_LIMIT)
    |-> file_addr == {(ins[7:0] < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH_BANK, ins[7:0]}; endproperty
  a_lit: assert property (p_lit) else $error("bad access address");
  property p_bank; file_rd_en && ins[8] |-> file_addr == {bank_select_register, ins[7:0]}; endproperty
  a_bank: assert property (p_bank) else $error("bad banked address");
  property p_jump; $rose(pc_load) |-> $past(discard_fetch); endproperty
  a_jump: assert property (p_jump) else $error("load without discard");
  property p_skip; clk_en && discard_fetch |=> nop_cycle; endproperty
  a_skip: assert property (p_skip) else $error("no nop after discard");
endmodule : byte_op_decode_props
bind byte_op_decode_indexed_offset byte_op_decode_props i_props (.*);

/* File: verification/program_data_model.sv */
`timescale 1ns/10ps
module program_data_model
  import byte_op_decode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire q_phase_t    phase,
  input  wire logic        file_rd_en,
  input  wire logic [11:0] file_addr,
  input  wire logic        file_wr_en,
  input  wire logic [7:0]  file_wr_data,
  output logic      [7:0]  file_rd_data,
  output logic      [15:0] fetch_word
);
  logic [15:0] prog [0:31];
  logic [7:0]  ram [0:4095];
  logic [4:0]  pc;
  // An idle data bus shows the inverted cell, so a mistimed sample never matches.
  assign file_rd_data = file_rd_en ? ram[file_addr] : ~ram[file_addr];
  assign fetch_word   = prog[pc];
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ 8'h5A;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) pc <= 5'h00;
    else if (clk_en && phase == PHASE_WRITE) pc <= pc + 5'h01;
    if (reset_n && clk_en && file_wr_en) ram[file_addr] <= file_wr_data;
  end
endmodule : program_data_model

/* File: verification/byte_op_decode_indexed_offset_bench.sv */
`timescale 1ns/10ps
module byte_op_decode_indexed_offset_bench import byte_op_decode_pkg::*;;
  typedef struct packed {
    logic [15:0] op; logic ext; logic [3:0] bs; logic [11:0] fp; logic [11:0] ad; logic wr; logic [7:0] dt;
  } row_t;
  logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b0, ext_set_enable = 1'b0;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] frame_pointer = 12'h000, file_addr;
  logic [15:0] fetch_word;
  logic [7:0]  file_rd_data, file_wr_data, w_reg;
  logic [20:0] pc_target;
  logic        file_rd_en, file_wr_en, carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag;
  logic        pc_load, discard_fetch, ext_op_decoded, nop_cycle;
  q_phase_t    phase;
  int          bad_count = 0, num_checks = 0;
  logic [15:0] tail [9] = '{16'h6207, 16'hEF00, 16'hF000, 16'hEF34, 16'hF123, 16'hE800, 16'h0014,
                            16'hEF55, 16'h0000};
  row_t        rows [11] = '{
    '{16'h2A10, 1'b0, 4'h0, 12'h000, 12'h010, 1'b1, 8'h4B}, '{16'h2A80, 1'b0, 4'h0, 12'h000, 12'hF80, 1'b1, 8'hDB},
    '{16'h2B22, 1'b0, 4'h3, 12'h000, 12'h322, 1'b1, 8'h79}, '{16'h2A05, 1'b1, 4'h0, 12'h200, 12'h205, 1'b1, 8'h60},
    '{16'h2A5F, 1'b1, 4'h0, 12'h200, 12'h25F, 1'b1, 8'h06}, '{16'h2A60, 1'b1, 4'h0, 12'h200, 12'hF60, 1'b1, 8'h3B},
    '{16'h2B10, 1'b1, 4'h3, 12'h200, 12'h310, 1'b1, 8'h4B}, '{16'h2A11, 1'b1, 4'h0, 12'h000, 12'h011, 1'b1, 8'h4C},
    '{16'h1E01, 1'b1, 4'h0, 12'h300, 12'h301, 1'b1, 8'hA4}, '{16'h2806, 1'b1, 4'h0, 12'h200, 12'h206, 1'b0, 8'h5D},
    '{16'h2AA5, 1'b1, 4'h0, 12'h200, 12'hFA5, 1'b1, 8'h00}};
  byte_op_decode_indexed_offset i_dut (.*);
  program_data_model i_mem (.*);
  always #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : step
  task automatic to_phase(input q_phase_t p);
    for (int i = 0; i < 8 && phase !== p; i++) step(1);
    check(phase, p);
  endtask : to_phase
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // The program needs about 90 cycles; a stuck phase sequencer runs into this limit.
  initial begin
    #(25 * 400);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 32; i++) i_mem.prog[i] = 16'h0000;
    foreach (rows[i]) i_mem.prog[i] = rows[i].op;
    foreach (tail[i]) i_mem.prog[11 + i] = tail[i];
    step(1);
    check({phase, file_wr_en}, 5'b00010);
    step(2);
    reset_n = 1'b1;
    step(2);
    check(phase, PHASE_DECODE);
    clk_en = 1'b1;
    step(4);
    foreach (rows[i]) begin
      to_phase(PHASE_DECODE);
      ext_set_enable = rows[i].ext;
      bank_select_register = rows[i].bs;
      frame_pointer = rows[i].fp;
      step(1);
      check({file_rd_en, file_addr}, {1'b1, rows[i].ad});
      step(2);
      check({file_wr_en, rows[i].wr ? file_wr_data : w_reg}, {rows[i].wr, rows[i].dt});
    end
    check({carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag}, 5'b11001);
    to_phase(PHASE_DECODE);
    ext_set_enable = 1'b0;
    step(3);
    check(discard_fetch, 1'b1);
    step(1);
    check(nop_cycle, 1'b1);
    step(4);
    check({nop_cycle, pc_load}, 2'b10);
    step(7);
    check(discard_fetch, 1'b1);
    step(1);
    check({pc_load, nop_cycle, pc_target}, {2'b11, 21'h024668});
    step(4);
    ext_set_enable = 1'b1;
    step(1);
    check(ext_op_decoded, 1'b1);
    step(3);
    ext_set_enable = 1'b0;
    step(1);
    check(ext_op_decoded, 1'b0);
    step(6);
    check(discard_fetch, 1'b0);
    step(1);
    check({pc_load, nop_cycle}, 2'b00);
    reset_n = 1'b0;
    step(1);
    check({phase, w_reg, pc_load, nop_cycle}, {PHASE_DECODE, 8'h00, 2'b00});
    reset_n = 1'b1;
    step(1);
    check({phase, file_rd_en}, {PHASE_READ, 1'b0});
    tally_and_finish();
  end
endmodule : byte_op_decode_indexed_offset_bench
